/* File: src/prog_port_defs.vh */
// constants for the serial programming port of the configuration memory
`ifndef PROG_PORT_DEFS_VH
`define PROG_PORT_DEFS_VH
`define ST_IDLE 3'h0
`define ST_DEV 3'h1
`define ST_ADDR 3'h2
`define ST_WDATA 3'h3
`define ST_RDATA 3'h4
`define ST_BUSY 3'h5
`define ST_ERASE 3'h6
`define DEV_RW_BIT 0
`define INSTR_BIT 1
`define INSTR_ERASE 1'b1
`define INSTR_MEM 1'b0
`define SEC_ERASE_BIT 2
`define SEC_SET_BIT 3
`define ADDR_BYTES 2'h3
`define WRITE_TIME_NS 32'd10000
`define CLK_PERIOD_NS 32'd10
`define WRITE_CYCLES (`WRITE_TIME_NS / `CLK_PERIOD_NS)
`define ARRAY_RESET 8'h00
`endif

/* File: src/prog_fifo.v */
// parameterised valid/ready fifo
`timescale 1ns/1ps
module prog_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk,
    input wire resetn,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem[rd_q];
    always @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end
    always @(posedge clk) begin
        if (!resetn) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // prog_fifo

/* File: src/prog_port.v */
// two-wire serial programming port with security bit for a configuration memory
`timescale 1ns/1ps
`include "prog_port_defs.vh"
module prog_port #(
    parameter ADDR_W = 10,
    parameter WRITE_CYCLES = `WRITE_CYCLES
) (
    input wire clk,
    input wire resetn,
    input wire prog_sel_n,
    input wire prog_serial_clock,
    input wire prog_serial_data_i,
    output reg prog_serial_data_o,
    output reg prog_serial_data_oe,
    input wire boot_req,
    output reg boot_valid,
    input wire boot_ready,
    output reg [7:0] boot_data,
    output reg secured,
    output reg busy
);
    reg [1:0] scl_s, sda_s, sel_s;
    reg scl_q, sda_q;
    reg [2:0] st_q;
    reg [3:0] bit_q;
    reg [7:0] sh_q;
    reg [1:0] abyte_q;
    reg [ADDR_W-1:0] addr_q;
    reg [ADDR_W-1:0] boot_addr_q;
    reg rd_q, erase_q, setsec_q, nack_q, wrpend_q, booting_q;
    reg [31:0] wcnt_q;
    reg [ADDR_W:0] ecnt_q;
    reg [7:0] mem [0:(1<<ADDR_W)-1];
    reg [7:0] wbuf_q;
    wire scl = scl_s[1];
    wire sda = sda_s[1];
    wire sel = !sel_s[1];
    wire rise = scl && !scl_q;
    wire fall = !scl && scl_q;
    wire start_c = scl && scl_q && sda_q && !sda;
    wire stop_c = scl && scl_q && !sda_q && sda;
    wire f_in_valid = booting_q && !busy;
    wire f_in_ready;
    wire f_out_valid;
    wire [7:0] f_out_data;
    wire [7:0] rd_byte = secured ? 8'h00 : mem[addr_q];
    wire refuse_dev = secured && !sh_q[`SEC_ERASE_BIT] && !sh_q[`INSTR_BIT];
    integer i;
    // boot stream buffered internally only, no path to the serial pins
    prog_fifo #(.WIDTH(8), .DEPTH(8), .AW(3)) boot_fifo (
        .clk(clk),
        .resetn(resetn),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(mem[boot_addr_q]),
        .out_valid(f_out_valid),
        .out_ready(boot_ready || !boot_valid),
        .out_data(f_out_data)
    );
    initial begin
        for (i = 0; i < (1<<ADDR_W); i = i + 1) begin
            mem[i] = `ARRAY_RESET;
        end
        // nonvolatile bit: a reset must not unlock a secured part
        secured = 1'b0;
    end
    always @(posedge clk) begin
        if (!resetn) begin
            scl_s <= 2'h3;
            sda_s <= 2'h3;
            sel_s <= 2'h3;
        end else begin
            scl_s <= {scl_s[0], prog_serial_clock};
            sda_s <= {sda_s[0], prog_serial_data_i};
            sel_s <= {sel_s[0], prog_sel_n};
        end
    end
    always @(posedge clk) begin
        if (!resetn) begin
            boot_valid <= 1'b0;
            boot_data <= 8'h00;
            boot_addr_q <= {ADDR_W{1'b0}};
            booting_q <= 1'b0;
        end else begin
            if (boot_req && !booting_q && !sel) begin
                booting_q <= 1'b1;
                boot_addr_q <= {ADDR_W{1'b0}};
            end else if (f_in_valid && f_in_ready) begin
                boot_addr_q <= boot_addr_q + 1'b1;
                if (&boot_addr_q) begin
                    booting_q <= 1'b0;
                end
            end
            if (boot_ready || !boot_valid) begin
                boot_valid <= f_out_valid;
                boot_data <= f_out_data;
            end
        end
    end
    // array write port: page byte, or whole-array erase
    always @(posedge clk) begin
        if (st_q == `ST_ERASE && !ecnt_q[ADDR_W]) begin
            mem[ecnt_q[ADDR_W-1:0]] <= 8'h00;
        end else if (st_q == `ST_BUSY && wrpend_q) begin
            mem[addr_q] <= wbuf_q;
        end
    end
    always @(posedge clk) begin
        if (!resetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            st_q <= `ST_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            abyte_q <= 2'h0;
            addr_q <= {ADDR_W{1'b0}};
            rd_q <= 1'b0;
            erase_q <= 1'b0;
            setsec_q <= 1'b0;
            nack_q <= 1'b0;
            wrpend_q <= 1'b0;
            wcnt_q <= 32'h0;
            ecnt_q <= {(ADDR_W+1){1'b0}};
            wbuf_q <= 8'h00;
            busy <= 1'b0;
            prog_serial_data_o <= 1'b0;
            prog_serial_data_oe <= 1'b0;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            prog_serial_data_o <= 1'b0;
            if (st_q == `ST_BUSY) begin
                // serial lines ignored for the whole timed cycle
                busy <= 1'b1;
                prog_serial_data_oe <= 1'b0;
                if (wcnt_q == 32'h0) begin
                    wrpend_q <= 1'b0;
                    if (erase_q) begin
                        ecnt_q <= {(ADDR_W+1){1'b0}};
                        st_q <= `ST_ERASE;
                    end else begin
                        if (setsec_q) begin
                            secured <= 1'b1;
                        end
                        busy <= 1'b0;
                        st_q <= `ST_IDLE;
                    end
                end else begin
                    wcnt_q <= wcnt_q - 1'b1;
                    if (wrpend_q) begin
                        wrpend_q <= 1'b0;
                        addr_q <= {addr_q[ADDR_W-1:7], addr_q[6:0] + 7'h1};
                    end
                end
            end else if (st_q == `ST_ERASE) begin
                ecnt_q <= ecnt_q + 1'b1;
                if (ecnt_q[ADDR_W]) begin
                    secured <= 1'b0;
                    erase_q <= 1'b0;
                    busy <= 1'b0;
                    st_q <= `ST_IDLE;
                end
            end else if (!sel) begin
                st_q <= `ST_IDLE;
                prog_serial_data_oe <= 1'b0;
            end else if (start_c) begin
                st_q <= `ST_DEV;
                bit_q <= 4'h0;
                nack_q <= 1'b0;
                // stale command bits must not act on the next stop
                rd_q <= 1'b0;
                erase_q <= 1'b0;
                setsec_q <= 1'b0;
                prog_serial_data_oe <= 1'b0;
            end else if (stop_c) begin
                prog_serial_data_oe <= 1'b0;
                if (st_q != `ST_IDLE && (erase_q || setsec_q || (st_q == `ST_WDATA))) begin
                    wcnt_q <= WRITE_CYCLES - 1;
                    busy <= 1'b1;
                    st_q <= `ST_BUSY;
                end else begin
                    st_q <= `ST_IDLE;
                end
            end else if (st_q != `ST_IDLE) begin
                if (rise) begin
                    if (bit_q < 4'h8) begin
                        // address bytes msb first, data lsb first
                        if (st_q == `ST_WDATA) begin
                            sh_q <= {sda, sh_q[7:1]};
                        end else if (st_q != `ST_RDATA) begin
                            sh_q <= {sh_q[6:0], sda};
                        end
                        bit_q <= bit_q + 1'b1;
                    end else begin
                        bit_q <= 4'h0;
                        if (st_q == `ST_RDATA) begin
                            if (sda) begin
                                st_q <= `ST_IDLE;
                            end else begin
                                addr_q <= addr_q + 1'b1;
                            end
                        end else if (st_q == `ST_DEV) begin
                            if (!nack_q) begin
                                rd_q <= sh_q[`DEV_RW_BIT];
                                erase_q <= secured ? (sh_q[`SEC_ERASE_BIT] || sh_q[`INSTR_BIT])
                                    : sh_q[`SEC_ERASE_BIT];
                                setsec_q <= sh_q[`SEC_SET_BIT] && !secured;
                                abyte_q <= 2'h0;
                                st_q <= `ST_ADDR;
                            end else begin
                                st_q <= `ST_IDLE;
                            end
                        end else if (st_q == `ST_ADDR) begin
                            addr_q <= {addr_q[ADDR_W-9:0], sh_q};
                            abyte_q <= abyte_q + 1'b1;
                            if (abyte_q == `ADDR_BYTES - 2'h1) begin
                                st_q <= rd_q ? `ST_RDATA : `ST_WDATA;
                            end
                        end else if (st_q == `ST_WDATA && !secured) begin
                            wbuf_q <= sh_q;
                            wrpend_q <= 1'b1;
                        end
                    end
                end else if (fall) begin
                    // drive starts only on the falling clock edge; start, stop and deselect also release it
                    prog_serial_data_oe <= 1'b0;
                    if (bit_q == 4'h8 && st_q != `ST_RDATA) begin
                        // refuse by release when secured and not erase
                        if (st_q == `ST_DEV) begin
                            prog_serial_data_oe <= !refuse_dev;
                        end else begin
                            prog_serial_data_oe <= !(secured && !erase_q);
                        end
                        nack_q <= refuse_dev && st_q == `ST_DEV;
                    end else if (st_q == `ST_RDATA && bit_q < 4'h8) begin
                        prog_serial_data_oe <= !rd_byte[bit_q[2:0]] && !secured;
                    end
                end
            end
        end
    end
endmodule // prog_port

/* File: tb/prog_port_checker.sv */
// assertion checker for the serial programming port
`timescale 1ns/1ps
module prog_port_checker #(
    parameter WRITE_CYCLES = 20
) (
    input wire clk,
    input wire resetn,
    input wire prog_sel_n,
    input wire prog_serial_clock,
    input wire prog_serial_data_i,
    input wire prog_serial_data_o,
    input wire prog_serial_data_oe,
    input wire boot_req,
    input wire boot_valid,
    input wire boot_ready,
    input wire [7:0] boot_data,
    input wire secured,
    input wire busy
);
    reg [11:0] busy_q;
    // length of the running timed cycle
    always @(posedge clk) begin
        busy_q <= (busy && resetn) ? busy_q + 12'h001 : 12'h000;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_od; prog_serial_data_oe |-> !prog_serial_data_o; endproperty
    a_od: assert property (p_od) else $error("data line driven high");
    property p_sel; prog_sel_n [*6] |-> !prog_serial_data_oe; endproperty
    a_sel: assert property (p_sel) else $error("drive while deselected");
    property p_rise; $rose(prog_serial_data_oe) |-> !prog_serial_clock; endproperty
    a_rise: assert property (p_rise) else $error("drive began with clock high");
    property p_quiet; busy |-> !prog_serial_data_oe; endproperty
    a_quiet: assert property (p_quiet) else $error("drive during timed cycle");
    property p_blen; $fell(busy) |-> busy_q >= WRITE_CYCLES - 1; endproperty
    a_blen: assert property (p_blen) else $error("timed cycle too short");
    property p_bhold; boot_valid && !boot_ready |=> boot_valid && $stable(boot_data); endproperty
    a_bhold: assert property (p_bhold) else $error("boot word dropped");
    property p_bpin; boot_valid |-> !prog_serial_data_oe; endproperty
    a_bpin: assert property (p_bpin) else $error("boot data on pins");
    property p_sclr; $fell(secured) |-> busy || $past(busy); endproperty
    a_sclr: assert property (p_sclr) else $error("security cleared without erase");
endmodule // prog_port_checker
bind prog_port prog_port_checker #(.WRITE_CYCLES(WRITE_CYCLES)) prog_port_checker_i (
    .clk(clk), .resetn(resetn), .prog_sel_n(prog_sel_n),
    .prog_serial_clock(prog_serial_clock), .prog_serial_data_i(prog_serial_data_i),
    .prog_serial_data_o(prog_serial_data_o), .prog_serial_data_oe(prog_serial_data_oe),
    .boot_req(boot_req), .boot_valid(boot_valid), .boot_ready(boot_ready),
    .boot_data(boot_data), .secured(secured), .busy(busy));

/* File: tb/prog_host.sv */
// programmer model: serial clock and open-drain data with pull-up
`timescale 1ns/1ps
module prog_host (
    input wire clk,
    input wire dev_o,
    input wire dev_oe,
    output reg scl,
    output wire sda
);
    reg pull_q = 1'b0;
    initial scl = 1'b1; // stands high between messages
    assign sda = !(pull_q || (dev_oe && !dev_o)); // pull-up, low only
    task tick(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    // data moves mid low phase, sampled while high
    task put_bit(input b, output s);
        begin
            scl = 1'b0;
            tick(2);
            pull_q = !b;
            tick(2);
            scl = 1'b1;
            tick(2);
            s = sda;
            tick(2);
        end
    endtask
    task start;
        begin
            scl = 1'b0;
            tick(4);
            pull_q = 1'b0;
            tick(2);
            scl = 1'b1;
            tick(4);
            pull_q = 1'b1;
            tick(4);
        end
    endtask
    task stop;
        begin
            scl = 1'b0;
            tick(4);
            pull_q = 1'b1;
            tick(4);
            scl = 1'b1;
            tick(4);
            pull_q = 1'b0;
            tick(4);
        end
    endtask
    task tx(input [7:0] v, input msb, output ack);
        integer i;
        reg s;
        begin
            for (i = 0; i < 8; i = i + 1)
                put_bit(msb ? v[7-i] : v[i], s);
            put_bit(1'b1, ack); // released for receiver answer
        end
    endtask
    task rx(input last, output [7:0] v);
        integer i;
        reg s;
        begin
            for (i = 0; i < 8; i = i + 1)
                put_bit(1'b1, v[i]);
            put_bit(last, s); // acks all but the last byte
        end
    endtask
endmodule // prog_host

/* File: tb/secure_config_eeprom_serial_prog_test.sv */
// self-checking bench for the serial programming port
`timescale 1ns/1ps
module secure_config_eeprom_serial_prog_test;
    reg clk = 1'b0;
    reg resetn;
    reg prog_sel_n;
    reg boot_req;
    reg boot_ready;
    wire scl, sda, sda_o, sda_oe, boot_valid, secured, busy;
    wire [7:0] boot_data;
    integer errors = 0;
    integer checks_done = 0;
    integer i;
    reg ack;
    reg [7:0] v;
    reg [31:0] rows [0:3];
    always #5 clk = ~clk;
    prog_port #(.ADDR_W(10), .WRITE_CYCLES(20)) prog_port_i (
        .clk(clk), .resetn(resetn), .prog_sel_n(prog_sel_n), .prog_serial_clock(scl),
        .prog_serial_data_i(sda), .prog_serial_data_o(sda_o), .prog_serial_data_oe(sda_oe),
        .boot_req(boot_req), .boot_valid(boot_valid), .boot_ready(boot_ready),
        .boot_data(boot_data), .secured(secured), .busy(busy));
    prog_host prog_host_i (.clk(clk), .dev_o(sda_o), .dev_oe(sda_oe), .scl(scl), .sda(sda));
    task print_verdict;
        begin
            $display("checks %0d errors %0d", checks_done, errors);
            if (errors == 0 && checks_done > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task pins(input rst_n, input sel_n, input req, input rdy);
        begin
            resetn = rst_n;
            prog_sel_n = sel_n;
            boot_req = req;
            boot_ready = rdy;
        end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task settle; // stop, then wait out the timed cycle
        integer n;
        begin
            prog_host_i.stop;
            prog_host_i.tick(8);
            n = 0;
            while (busy !== 1'b0 && n < 3000) begin
                prog_host_i.tick(1);
                n = n + 1;
            end
            if (n == 3000) begin
                errors = errors + 1;
                print_verdict;
            end
        end
    endtask
    task msg(input [7:0] dev, input [23:0] a, input exp_ack);
        integer j;
        begin
            prog_host_i.start;
            prog_host_i.tx(dev, 1'b1, ack);
            chk({7'h00, ack}, {7'h00, exp_ack});
            for (j = 2; j >= 0 && !exp_ack; j = j - 1) begin
                prog_host_i.tx(a[8*j +: 8], 1'b1, ack);
                chk({7'h00, ack}, 8'h00);
            end
        end
    endtask
    task wr(input [23:0] a, input [7:0] d);
        begin
            msg(8'h00, a, 1'b0);
            prog_host_i.tx(d, 1'b0, ack);
            chk({7'h00, ack}, 8'h00);
            settle;
        end
    endtask
    task rd(input [23:0] a, input [7:0] exp);
        begin
            msg(8'h01, a, 1'b0);
            prog_host_i.rx(1'b1, v);
            chk(v, exp);
            settle;
        end
    endtask
    initial begin
        rows[0] = {24'h000000, 8'ha5};
        rows[1] = {24'h000001, 8'h3c};
        rows[2] = {24'h00007f, 8'h5a};
        rows[3] = {24'h0003ff, 8'h81};
        pins(1'b0, 1'b0, 1'b0, 1'b0);
        repeat (6) @(posedge clk);
        #1;
        pins(1'b1, 1'b0, 1'b0, 1'b0);
        chk({4'h0, sda_oe, secured, busy, boot_valid}, 8'h00); // reset values
        prog_host_i.tick(4);
        rd(24'h000200, 8'h00);
        for (i = 0; i < 4; i = i + 1) begin
            wr(rows[i][31:8], rows[i][7:0]);
            rd(rows[i][31:8], rows[i][7:0]);
        end
        pins(1'b1, 1'b1, 1'b0, 1'b0);
        prog_host_i.tick(5);
        msg(8'h01, 24'h000000, 1'b1);
        settle;
        pins(1'b1, 1'b0, 1'b0, 1'b0);
        prog_host_i.tick(5);
        msg(8'h08, 24'h000000, 1'b0);
        settle;
        chk({7'h00, secured}, 8'h01);
        pins(1'b0, 1'b0, 1'b0, 1'b0);
        prog_host_i.tick(3);
        pins(1'b1, 1'b0, 1'b0, 1'b0);
        chk({4'h0, sda_oe, secured, busy, boot_valid}, 8'h04);
        prog_host_i.tick(4);
        msg(8'h00, 24'h000000, 1'b1);
        settle;
        msg(8'h01, 24'h000000, 1'b1);
        settle;
        pins(1'b1, 1'b1, 1'b0, 1'b0);
        prog_host_i.tick(5);
        pins(1'b1, 1'b1, 1'b1, 1'b0);
        prog_host_i.tick(1);
        pins(1'b1, 1'b1, 1'b0, 1'b0);
        prog_host_i.tick(60); // stalled: fifo fills up
        chk({7'h00, boot_valid}, 8'h01);
        chk(boot_data, 8'ha5);
        pins(1'b1, 1'b1, 1'b0, 1'b1);
        prog_host_i.tick(2500);
        chk({7'h00, boot_valid}, 8'h00); // drained
        pins(1'b1, 1'b0, 1'b0, 1'b1);
        prog_host_i.tick(5);
        msg(8'h03, 24'h000000, 1'b0);
        prog_host_i.rx(1'b0, v);
        chk(v, 8'hff);
        settle;
        chk({7'h00, secured}, 8'h00);
        prog_host_i.start;
        for (i = 0; i < 3; i = i + 1)
            prog_host_i.put_bit(1'b0, ack);
        rd(24'h000001, 8'h00);
        wr(24'h000001, 8'h96);
        rd(24'h000001, 8'h96);
        print_verdict;
    end
endmodule // secure_config_eeprom_serial_prog_test
